// [ptc_pkg.sv]
package ptc_pkg;
    localparam int PTC_IDX_W = 8;
    localparam logic [PTC_IDX_W-1:0] PTC_IDX_RST = 8'h00;
    localparam logic [1:0] PTC_SYNC_RST = 2'h0;
    localparam int PTC_EXPOSE_NS = 1000;
    localparam int PTC_CLK_NS = 10;
    localparam int PTC_EXPOSE_CYC =
        (PTC_EXPOSE_NS + PTC_CLK_NS - 1) / PTC_CLK_NS;
    localparam int PTC_CNT_W = 16;

    typedef enum logic [1:0] {
        PTC_IDLE = 2'b00,
        PTC_EXPOSE = 2'b01,
        PTC_WAIT = 2'b10
    } ptc_state_type;

    typedef struct packed {
        logic exposure_active_output;
        logic first_pattern_output;
    } ptc_trig_out_type;
endpackage

// [ptc_trigger_ctrl.sv]
`timescale 1ns/1ps
module ptc_trigger_ctrl (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic role_master,
    input wire logic pattern_advance_input,
    input wire logic pattern_run_input,
    input wire logic sw_start,
    input wire logic sw_stop,
    input wire logic [ptc_pkg::PTC_IDX_W-1:0] seq_length,
    output ptc_pkg::ptc_trig_out_type trig_out,
    output logic running,
    output logic [ptc_pkg::PTC_IDX_W-1:0] pattern_index
);
    import ptc_pkg::*;

    logic [1:0] adv_sync_r, adv_sync_nxt;
    logic [1:0] run_sync_r, run_sync_nxt;
    logic adv_q_r, adv_q_nxt, run_q_r, run_q_nxt;
    logic adv_rise, run_rise, run_fall, is_master;

    ptc_state_type state_r, state_nxt;
    logic run_r, run_nxt;
    logic [PTC_IDX_W-1:0] idx_r, idx_nxt;
    logic [PTC_CNT_W-1:0] cnt_r, cnt_nxt;
    ptc_trig_out_type out_r, out_nxt;

    function automatic logic [PTC_IDX_W-1:0] next_idx(
        input logic [PTC_IDX_W-1:0] cur,
        input logic [PTC_IDX_W-1:0] len);
        if (cur + 8'h01 >= len)
            next_idx = PTC_IDX_RST;
        else
            next_idx = cur + 8'h01;
    endfunction

    assign is_master = role_master;

    always_comb begin
        adv_sync_nxt = {adv_sync_r[0], pattern_advance_input};
        run_sync_nxt = {run_sync_r[0], pattern_run_input};
        adv_q_nxt = adv_sync_r[1];
        run_q_nxt = run_sync_r[1];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            adv_sync_r <= PTC_SYNC_RST;
            run_sync_r <= PTC_SYNC_RST;
            adv_q_r <= 1'h0;
            run_q_r <= 1'h0;
        end else begin
            adv_sync_r <= adv_sync_nxt;
            run_sync_r <= run_sync_nxt;
            adv_q_r <= adv_q_nxt;
            run_q_r <= run_q_nxt;
        end
    end

    // slave ignores every trigger pin
    assign adv_rise = is_master & adv_sync_r[1] & ~adv_q_r;
    assign run_rise = is_master & run_sync_r[1] & ~run_q_r;
    assign run_fall = is_master & ~run_sync_r[1] & run_q_r;

    always_comb begin
        state_nxt = state_r;
        run_nxt = run_r;
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        // stop wins when start and stop coincide
        if (run_rise || sw_start)
            run_nxt = 1'h1;
        if (run_fall || sw_stop)
            run_nxt = 1'h0;
        unique case (state_r)
            PTC_IDLE: begin
                if (run_nxt) begin
                    state_nxt = PTC_EXPOSE;
                    idx_nxt = PTC_IDX_RST;
                    cnt_nxt = PTC_CNT_W'(PTC_EXPOSE_CYC - 1);
                end
            end
            PTC_EXPOSE: begin
                if (!run_nxt)
                    state_nxt = PTC_IDLE;
                else if (cnt_r == '0)
                    state_nxt = PTC_WAIT;
                else
                    cnt_nxt = cnt_r - 16'h0001;
            end
            PTC_WAIT: begin
                if (!run_nxt)
                    state_nxt = PTC_IDLE;
                else if (adv_rise) begin
                    state_nxt = PTC_EXPOSE;
                    idx_nxt = next_idx(idx_r, seq_length);
                    cnt_nxt = PTC_CNT_W'(PTC_EXPOSE_CYC - 1);
                end
            end
            default: state_nxt = PTC_IDLE;
        endcase
        // outputs held low on a slave
        out_nxt.exposure_active_output =
            is_master & (state_nxt == PTC_EXPOSE);
        out_nxt.first_pattern_output = is_master &
            (state_nxt != PTC_IDLE) & (idx_nxt == PTC_IDX_RST);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= PTC_IDLE;
            run_r <= 1'h0;
            idx_r <= PTC_IDX_RST;
            cnt_r <= '0;
            out_r <= '0;
        end else begin
            state_r <= state_nxt;
            run_r <= run_nxt;
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign trig_out = out_r;
    assign running = run_r;
    assign pattern_index = idx_r;

    // exposure length tracker, read only by the assertions below
    logic [PTC_CNT_W-1:0] exp_run_r, exp_run_nxt;

    always_comb begin
        if (trig_out.exposure_active_output)
            exp_run_nxt = exp_run_r + 16'h0001;
        else
            exp_run_nxt = '0;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            exp_run_r <= '0;
        else
            exp_run_r <= exp_run_nxt;
    end

    property p_start_edge;
        @(posedge ref_clk) disable iff (!resetn)
        (run_rise && !run_fall && !sw_stop) |=> run_r;
    endproperty
    a_start_edge: assert property (p_start_edge)
        else $error("run rise did not start");

    property p_stop_edge;
        @(posedge ref_clk) disable iff (!resetn)
        run_fall |=> !run_r && !trig_out.exposure_active_output;
    endproperty
    a_stop_edge: assert property (p_stop_edge)
        else $error("run fall did not stop");

    property p_sw_ctrl;
        @(posedge ref_clk) disable iff (!resetn)
        sw_stop |=> !run_r;
    endproperty
    a_sw_ctrl: assert property (p_sw_ctrl)
        else $error("software stop ignored");

    property p_advance;
        @(posedge ref_clk) disable iff (!resetn)
        (state_r == PTC_WAIT && adv_rise && run_nxt) |=>
            (pattern_index == next_idx($past(idx_r), $past(seq_length)))
            && trig_out.exposure_active_output;
    endproperty
    a_advance: assert property (p_advance)
        else $error("advance did not step pattern");

    property p_expose;
        @(posedge ref_clk) disable iff (!resetn)
        trig_out.exposure_active_output |-> (state_r == PTC_EXPOSE);
    endproperty
    a_expose: assert property (p_expose)
        else $error("exposure output outside exposure");

    property p_expose_max;
        @(posedge ref_clk) disable iff (!resetn)
        exp_run_r <= PTC_CNT_W'(PTC_EXPOSE_CYC);
    endproperty
    a_expose_max: assert property (p_expose_max)
        else $error("exposure output stood too long");

    property p_expose_len;
        @(posedge ref_clk) disable iff (!resetn)
        $fell(trig_out.exposure_active_output) && running &&
            $past(role_master) |->
            (exp_run_r == PTC_CNT_W'(PTC_EXPOSE_CYC));
    endproperty
    a_expose_len: assert property (p_expose_len)
        else $error("exposure ended early");

    property p_first;
        @(posedge ref_clk) disable iff (!resetn)
        trig_out.first_pattern_output |->
            (pattern_index == PTC_IDX_RST) && (state_r != PTC_IDLE);
    endproperty
    a_first: assert property (p_first)
        else $error("first pattern output wrong");

    property p_first_start;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(running) && $past(role_master) |->
            trig_out.first_pattern_output &&
            trig_out.exposure_active_output;
    endproperty
    a_first_start: assert property (p_first_start)
        else $error("start did not show first pattern");

    property p_slave_quiet;
        @(posedge ref_clk) disable iff (!resetn)
        (!role_master && !$past(role_master)) |->
            !trig_out.exposure_active_output && !trig_out.first_pattern_output;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet)
        else $error("slave drove trigger output");

    property p_role;
        @(posedge ref_clk) disable iff (!resetn)
        (!role_master && !sw_start && !sw_stop) |=> $stable(running);
    endproperty
    a_role: assert property (p_role)
        else $error("slave reacted to trigger pin");

    property p_sync;
        @(posedge ref_clk) disable iff (!resetn)
        run_rise |->
            $past(pattern_run_input, 2) && !$past(pattern_run_input, 3);
    endproperty
    a_sync: assert property (p_sync)
        else $error("edge not two stages late");
endmodule

// [ptc_trig_source.sv]
`timescale 1ns/1ps
module ptc_trig_source (
    input wire logic ref_clk,
    input wire logic adv_req,
    input wire logic run_req,
    output logic pattern_advance_input,
    output logic pattern_run_input
);
    logic [2:0] adv_cnt;
    initial begin
        adv_cnt = 3'h0;
        pattern_advance_input = 1'h0;
        pattern_run_input = 1'h0;
    end
    // pins move off the clock edge, as an unrelated source would
    always @(posedge ref_clk) begin
        adv_cnt <= adv_req ? 3'h4 : adv_cnt - {2'h0, adv_cnt != 3'h0};
        pattern_advance_input <= #3 adv_req || adv_cnt > 3'h1;
        pattern_run_input <= #3 run_req;
    end
endmodule

// [pattern_trigger_control_bench.sv]
`timescale 1ns/1ps
module pattern_trigger_control_bench;
    import ptc_pkg::*;
    logic ref_clk, resetn, role_master, sw_start, sw_stop, adv_req, run_req;
    logic pa, pr, running, prev_exp;
    logic [7:0] seq_length, pattern_index, len;
    ptc_trig_out_type trig_out;
    logic [8:0] exp_q[$];
    int n_fail, cmp_count;
    ptc_trig_source i_src (.ref_clk(ref_clk), .adv_req(adv_req),
        .run_req(run_req), .pattern_advance_input(pa),
        .pattern_run_input(pr));
    ptc_trigger_ctrl i_dut (.ref_clk(ref_clk), .resetn(resetn),
        .role_master(role_master), .pattern_advance_input(pa),
        .pattern_run_input(pr), .sw_start(sw_start), .sw_stop(sw_stop),
        .seq_length(seq_length), .trig_out(trig_out), .running(running),
        .pattern_index(pattern_index));
    function automatic logic [7:0] lfsr(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task cyc(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(string nm, logic [8:0] e, logic [8:0] s);
        cmp_count++;
        if (s !== e) begin
            $display("BAD %s exp %h got %h", nm, e, s);
            n_fail++;
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    // each new exposure is matched against the oldest note
    always @(posedge ref_clk) begin
        prev_exp <= trig_out.exposure_active_output;
        if (trig_out.exposure_active_output === 1'h1 &&
            prev_exp !== 1'h1) begin
            if (exp_q.size() == 0)
                chk("unexpected exposure", 9'h000, 9'h1ff);
            else
                chk("first,index", exp_q.pop_front(),
                    {trig_out.first_pattern_output, pattern_index});
        end
    end
    initial begin
        #40000;
        n_fail++;
        stop_test();
    end
    initial begin
        {resetn, sw_start, sw_stop, adv_req, run_req} = 5'h0;
        role_master = 1'h1;
        len = lfsr(8'h19);
        len = 8'h02 + {6'h00, len[1:0]};
        seq_length = len;
        cyc(6);
        resetn <= 1'h1;
        cyc(2);
        exp_q.push_back(9'h100);
        sw_start <= 1'h1;
        cyc(1);
        sw_start <= 1'h0;
        cyc(50);
        chk("exposure", 9'h001,
            {8'h00, trig_out.exposure_active_output});
        cyc(60);
        chk("exposure", 9'h000,
            {8'h00, trig_out.exposure_active_output});
        $display("software start done");
        for (int i = 1; i <= len; i++) begin
            exp_q.push_back({i % len == 0, 8'(i % len)});
            adv_req <= 1'h1;
            cyc(1);
            adv_req <= 1'h0;
            cyc(110);
        end
        $display("advance wrap done");
        sw_start <= 1'h1;
        sw_stop <= 1'h1;
        cyc(1);
        {sw_start, sw_stop} <= 2'h0;
        cyc(2);
        chk("running", 9'h000, {8'h00, running});
        exp_q.push_back(9'h100);
        run_req <= 1'h1;
        cyc(5);
        // an advance edge while exposing must be dropped
        adv_req <= 1'h1;
        cyc(1);
        adv_req <= 1'h0;
        cyc(14);
        chk("running", 9'h001, {8'h00, running});
        chk("index", 9'h000, {1'h0, pattern_index});
        run_req <= 1'h0;
        cyc(8);
        chk("running", 9'h000, {8'h00, running});
        $display("run pin done");
        role_master <= 1'h0;
        run_req <= 1'h1;
        adv_req <= 1'h1;
        cyc(10);
        chk("slave outputs", 9'h000,
            {6'h00, running, trig_out});
        chk("notes left", 9'h000, 9'(exp_q.size()));
        $display("slave role done");
        stop_test();
    end
endmodule
